// >>> rtl/dpcm_top.sv
// Paged register window onto the playback program memory and the two
// record coefficient buffers, as an Avalon-MM slave with waitrequest.
// Assumes word addressing (one register per word) and that the mode and
// power inputs come synchronous from the codec core.
`timescale 1ns/1ps
module dpcm_top
(
  input wire logic ref_clk_in,            // 40 MHz core clock.
  input wire logic rst_n_in,              // Asynchronous reset, active low.
  input wire logic [6:0] avs_address_in,  // Register index in the page.
  input wire logic avs_read_in,           // Read request.
  input wire logic avs_write_in,          // Write request.
  input wire logic [7:0] avs_writedata_in, // Write byte.
  output logic [7:0] avs_readdata_out,    // Read byte.
  output logic avs_waitrequest_out,       // Low for the answering cycle.
  input wire logic prog_mode_en_in,       // Programmable engine mode on.
  input wire logic playback_pwr_in,       // Playback channel powered.
  input wire logic [10:0] eng_addr_in,    // Engine instruction number.
  output logic [23:0] eng_instr_out       // Fetched instruction word.
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dpcm_pkg::dpcm_state_t state_r;  // Bus handshake state.
  dpcm_pkg::dpcm_state_t state_nxt;
  logic [7:0] page_r;              // Page selector.
  logic [7:0] page_nxt;
  logic wait_r;                    // Registered waitrequest.
  logic wait_nxt;
  logic [7:0] rdata_r;             // Registered read byte.
  logic [7:0] rdata_nxt;
  logic [23:0] eng_r;              // Registered engine fetch.
  logic [23:0] eng_nxt;
  logic [7:0] imem [dpcm_pkg::INSTR_BYTES]; // Program bytes.

  dpcm_pkg::dpcm_dec_t dec;        // Decoded current access.
  logic locked;                    // Program window closed to the host.
  logic imem_we;                   // Program byte write strobe.
  logic wr_commit;                 // Write takes effect this edge.
  logic a_we;                      // Buffer A write strobe.
  logic b_we;                      // Buffer B write strobe.
  logic a_busy;                    // Buffer A loading defaults.
  logic b_busy;                    // Buffer B loading defaults.
  logic [7:0] a_rdata;             // Buffer A byte.
  logic [7:0] b_rdata;             // Buffer B byte.
  logic [12:0] eng_base;           // First byte of the fetched word.

  // ----------------------------------------------------------------------
  // Address decode of page and register index
  // ----------------------------------------------------------------------
  always_comb
  begin
    logic [6:0] off;
    logic [7:0] rel_a;
    logic [7:0] rel_b;
    logic [8:0] n_a;
    logic [8:0] n_b;
    off = 7'(avs_address_in - dpcm_pkg::REG_DATA_LO);
    rel_a = 8'(page_r - dpcm_pkg::COEF_A_PAGE_LO);
    rel_b = 8'(page_r - dpcm_pkg::COEF_B_PAGE_LO);
    n_a = 9'(rel_a[3:0] * dpcm_pkg::COEFS_PER_PAGE + {4'h0, off[6:2]});
    n_b = 9'(rel_b[3:0] * dpcm_pkg::COEFS_PER_PAGE + {4'h0, off[6:2]});
    dec.tgt = dpcm_pkg::TGT_NONE;
    dec.ibyte = 13'(13'(page_r - dpcm_pkg::INSTR_PAGE_LO)
                * dpcm_pkg::BYTES_PER_PAGE + {6'h00, off});
    dec.cidx = 8'h00;
    dec.lane = off[1:0];
    if (avs_address_in == dpcm_pkg::REG_PAGE_SEL)
    begin
      dec.tgt = dpcm_pkg::TGT_PAGE;
    end
    else if (avs_address_in < dpcm_pkg::REG_DATA_LO)
    begin
      dec.tgt = dpcm_pkg::TGT_NONE;
    end
    else if (page_r >= dpcm_pkg::INSTR_PAGE_LO &&
             page_r <= dpcm_pkg::INSTR_PAGE_HI)
    begin
      dec.tgt = dpcm_pkg::TGT_INSTR;
    end
    else if (rel_a < dpcm_pkg::COEF_PAGES && n_a < dpcm_pkg::COEF_NUM &&
             off[1:0] != dpcm_pkg::LANE_RSV)
    begin
      dec.tgt = dpcm_pkg::TGT_COEFA;
      dec.cidx = n_a[7:0];
    end
    else if (rel_b < dpcm_pkg::COEF_PAGES && n_b < dpcm_pkg::COEF_NUM &&
             off[1:0] != dpcm_pkg::LANE_RSV)
    begin
      dec.tgt = dpcm_pkg::TGT_COEFB;
      dec.cidx = n_b[7:0];
    end
  end

  // The running engine owns its program; the host may not disturb it.
  assign locked = prog_mode_en_in && playback_pwr_in;
  assign wr_commit = (state_r == dpcm_pkg::ST_ACK) && avs_write_in;
  assign imem_we = wr_commit && dec.tgt == dpcm_pkg::TGT_INSTR
                   && !locked;
  assign a_we = wr_commit && dec.tgt == dpcm_pkg::TGT_COEFA;
  assign b_we = wr_commit && dec.tgt == dpcm_pkg::TGT_COEFB;

  // ----------------------------------------------------------------------
  // Coefficient buffers
  // ----------------------------------------------------------------------
  dpcm_coef_buf #(.N(256)) u_buf_a
  (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(a_we),
    .idx_in(dec.cidx),
    .lane_in(dec.lane),
    .wdata_in(avs_writedata_in),
    .rdata_out(a_rdata),
    .busy_out(a_busy)
  );

  dpcm_coef_buf #(.N(256)) u_buf_b
  (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(b_we),
    .idx_in(dec.cidx),
    .lane_in(dec.lane),
    .wdata_in(avs_writedata_in),
    .rdata_out(b_rdata),
    .busy_out(b_busy)
  );

  // ----------------------------------------------------------------------
  // Bus handshake: one waiting cycle, then one answering cycle.
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    page_nxt = page_r;
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    unique case (state_r)
      dpcm_pkg::ST_INIT:
      begin
        // Hold the bus off until both buffers carry their defaults.
        if (!a_busy && !b_busy)
        begin
          state_nxt = dpcm_pkg::ST_IDLE;
        end
      end
      dpcm_pkg::ST_IDLE:
      begin
        if (avs_read_in || avs_write_in)
        begin
          state_nxt = dpcm_pkg::ST_ACK;
          wait_nxt = 1'b0;
          unique case (dec.tgt)
            dpcm_pkg::TGT_PAGE: rdata_nxt = page_r;
            dpcm_pkg::TGT_INSTR:
              rdata_nxt = locked ? 8'h00 : imem[dec.ibyte];
            dpcm_pkg::TGT_COEFA: rdata_nxt = a_rdata;
            dpcm_pkg::TGT_COEFB: rdata_nxt = b_rdata;
            default: rdata_nxt = 8'h00;
          endcase
        end
      end
      dpcm_pkg::ST_ACK:
      begin
        state_nxt = dpcm_pkg::ST_IDLE;
        if (wr_commit && dec.tgt == dpcm_pkg::TGT_PAGE)
        begin
          page_nxt = avs_writedata_in;
        end
      end
      default:
      begin
        state_nxt = dpcm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= dpcm_pkg::ST_INIT;
      page_r <= dpcm_pkg::PAGE_RESET;
      wait_r <= 1'b1;
      rdata_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      page_r <= page_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Program bytes hold no reset value; software loads them.
  always_ff @(posedge ref_clk_in)
  begin
    if (imem_we)
    begin
      imem[dec.ibyte] <= avs_writedata_in;
    end
  end

  // ----------------------------------------------------------------------
  // Engine fetch port: three bytes, high byte at the lowest address.
  // ----------------------------------------------------------------------
  assign eng_base = 13'({2'h0, eng_addr_in} * 13'h0003);

  always_comb
  begin
    eng_nxt = 24'h000000;
    if (eng_addr_in < dpcm_pkg::INSTR_WORDS)
    begin
      eng_nxt = {imem[eng_base], imem[13'(eng_base + 13'h0001)],
                 imem[13'(eng_base + 13'h0002)]};
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      eng_r <= 24'h000000;
    end
    else
    begin
      eng_r <= eng_nxt;
    end
  end

  assign avs_readdata_out = rdata_r;
  assign avs_waitrequest_out = wait_r;
  assign eng_instr_out = eng_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_init_waits: assert property (
    state_r == dpcm_pkg::ST_INIT |-> wait_r)
    else $error("Bus answered during default load.");
  a_init_bounded: assert property (
    state_r == dpcm_pkg::ST_INIT |-> ##[0:260] state_r != dpcm_pkg::ST_INIT)
    else $error("Default load did not finish.");
  a_ack_single: assert property (
    !wait_r |=> wait_r)
    else $error("Answer stood more than one cycle.");
  a_page_update: assert property (
    wr_commit && avs_address_in == dpcm_pkg::REG_PAGE_SEL
    |=> page_r == $past(avs_writedata_in))
    else $error("Page selector not written.");
  a_rsv_zero: assert property (
    state_r == dpcm_pkg::ST_IDLE && avs_read_in &&
    avs_address_in >= dpcm_pkg::REG_RSV_LO &&
    avs_address_in <= dpcm_pkg::REG_RSV_HI |=> rdata_r == 8'h00 && !wait_r)
    else $error("Reserved register read non-zero.");
  a_lock_read: assert property (
    state_r == dpcm_pkg::ST_IDLE && avs_read_in && locked &&
    dec.tgt == dpcm_pkg::TGT_INSTR |=> rdata_r == 8'h00)
    else $error("Locked program byte was read.");
  // Watches the stored byte itself, so a broken write gate is caught.
  a_lock_write: assert property (
    wr_commit && locked && dec.tgt == dpcm_pkg::TGT_INSTR
    |=> imem[$past(dec.ibyte)] == $past(imem[dec.ibyte]))
    else $error("Locked program byte was written.");
  a_instr_read: assert property (
    state_r == dpcm_pkg::ST_IDLE && avs_read_in && !locked &&
    dec.tgt == dpcm_pkg::TGT_INSTR |=> rdata_r == $past(imem[dec.ibyte]))
    else $error("Program byte read wrong.");
  a_coef_rsv: assert property (
    state_r == dpcm_pkg::ST_IDLE && avs_read_in &&
    page_r == dpcm_pkg::COEF_A_PAGE_LO && avs_address_in == 7'h0B
    |=> rdata_r == 8'h00)
    else $error("Reserved coefficient byte read non-zero.");

endmodule

// >>> rtl/dpcm_pkg.sv
// Constants, types and the reset-default table of the paged program and
// coefficient memory. Assumes a byte-wide register window of 128 registers
// per page, reached one register per aligned 32-bit bus word.
//
// What this block does
// - Store playback engine program as 24-bit words.
// - Instruction bytes: pages 0x98-0xBA, registers 0x08-0x7F.
// - Engine fetches its program from this memory.
// - Refuse instruction access when programmable and powered.
// - Buffer A: pages 8-16, 30 coefficients per page.
// - Buffer B: same layout on pages 26-34.
// - Register 0 selects page, resets to zero.
// - Reset loads fixed defaults into both buffers.
package dpcm_pkg;

  // ----------------------------------------------------------------------
  // Register window layout
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 7;                        // Register index width.
  localparam logic [6:0] REG_PAGE_SEL = 7'h00;      // Page selector index.
  localparam logic [6:0] REG_RSV_LO = 7'h01;        // First reserved index.
  localparam logic [6:0] REG_RSV_HI = 7'h07;        // Last reserved index.
  localparam logic [6:0] REG_DATA_LO = 7'h08;       // First data index.
  localparam logic [7:0] PAGE_RESET = 8'h00;        // Page after reset.

  // ----------------------------------------------------------------------
  // Instruction memory
  // ----------------------------------------------------------------------
  localparam logic [7:0] INSTR_PAGE_LO = 8'h98;     // First program page.
  localparam logic [7:0] INSTR_PAGE_HI = 8'hBA;     // Last program page.
  localparam logic [12:0] BYTES_PER_PAGE = 13'h0078; // 120 bytes a page.
  localparam int INSTR_BYTES = 4200;                // 35 pages of 120.
  localparam logic [10:0] INSTR_WORDS = 11'h578;    // 1400 words of 3 bytes.

  // ----------------------------------------------------------------------
  // Coefficient buffers
  // ----------------------------------------------------------------------
  localparam logic [7:0] COEF_A_PAGE_LO = 8'h08;    // Buffer A first page.
  localparam logic [7:0] COEF_B_PAGE_LO = 8'h1A;    // Buffer B first page.
  localparam logic [7:0] COEF_PAGES = 8'h09;        // Pages per buffer.
  localparam logic [8:0] COEFS_PER_PAGE = 9'h01E;   // 30 groups a page.
  localparam logic [8:0] COEF_NUM = 9'h100;         // 256 coefficients.
  localparam logic [1:0] LANE_RSV = 2'h3;           // Reserved group byte.

  // Reset defaults, 32-bit as printed; the top 24 bits are stored.
  localparam logic [31:0] DEF_ZERO = 32'h00000000;
  localparam logic [31:0] DEF_C1 = 32'h01170000;
  localparam logic [31:0] DEF_C3 = 32'h7DD30000;
  localparam logic [31:0] DEF_UNIT = 32'h07FFFF00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_INIT = 3'b001,
    ST_IDLE = 3'b010,
    ST_ACK = 3'b100
  } dpcm_state_t;

  typedef enum logic [2:0]
  {
    TGT_NONE = 3'h0,
    TGT_PAGE = 3'h1,
    TGT_INSTR = 3'h2,
    TGT_COEFA = 3'h3,
    TGT_COEFB = 3'h4
  } dpcm_tgt_t;

  // One decoded register access.
  typedef struct packed
  {
    dpcm_tgt_t tgt;
    logic [12:0] ibyte;
    logic [7:0] cidx;
    logic [1:0] lane;
  } dpcm_dec_t;

  // Default value of coefficient n after reset.
  function automatic logic [23:0] coef_default(input logic [7:0] n);
    logic [31:0] v;
    v = DEF_ZERO;
    case (n)
      8'h01, 8'h02: v = DEF_C1;
      8'h03: v = DEF_C3;
      8'h04, 8'h07, 8'h0C, 8'h11, 8'h16, 8'h1B,
      8'h24, 8'h27, 8'h2C, 8'h31, 8'h36, 8'h3B: v = DEF_UNIT;
      default: v = DEF_ZERO;
    endcase
    return v[31:8];
  endfunction

endpackage

// >>> rtl/dpcm_coef_buf.sv
// One 256 x 24-bit coefficient buffer with byte-lane access.
// Assumes the caller holds the address steady while a write is enabled.
`timescale 1ns/1ps
module dpcm_coef_buf
#(
  parameter int N = 256
)
(
  input wire logic clk_in,          // Core clock.
  input wire logic rst_n_in,        // Asynchronous reset, active low.
  input wire logic wr_en_in,        // Byte write strobe.
  input wire logic [7:0] idx_in,    // Coefficient number.
  input wire logic [1:0] lane_in,   // 0 = bits 23:16 .. 2 = bits 7:0.
  input wire logic [7:0] wdata_in,  // Byte to write.
  output logic [7:0] rdata_out,     // Selected byte, combinational.
  output logic busy_out             // High while defaults are loaded.
);

  logic [23:0] mem [N];             // Coefficient storage.
  logic [8:0] ptr_r;                // Default-load pointer.
  logic [8:0] ptr_nxt;
  logic busy_r;                     // Default load in progress.
  logic busy_nxt;
  logic [23:0] word;                // Addressed coefficient.

  // ----------------------------------------------------------------------
  // Default loader: a RAM cannot take a reset, so walk it once.
  // ----------------------------------------------------------------------
  always_comb
  begin
    ptr_nxt = ptr_r;
    busy_nxt = busy_r;
    if (busy_r)
    begin
      ptr_nxt = 9'(ptr_r + 9'h001);
      busy_nxt = (9'(ptr_r + 9'h001) != 9'(N));
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ptr_r <= 9'h000;
      busy_r <= 1'b1;
    end
    else
    begin
      ptr_r <= ptr_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Storage: loader wins; host writes only land once it is done.
  always_ff @(posedge clk_in)
  begin
    if (busy_r)
    begin
      mem[ptr_r[7:0]] <= dpcm_pkg::coef_default(ptr_r[7:0]);
    end
    else if (wr_en_in)
    begin
      unique case (lane_in)
        2'h0: mem[idx_in][23:16] <= wdata_in;
        2'h1: mem[idx_in][15:8] <= wdata_in;
        2'h2: mem[idx_in][7:0] <= wdata_in;
        default: ;
      endcase
    end
  end

  // Byte lane read, high byte first.
  always_comb
  begin
    word = mem[idx_in];
    unique case (lane_in)
      2'h0: rdata_out = word[23:16];
      2'h1: rdata_out = word[15:8];
      2'h2: rdata_out = word[7:0];
      default: rdata_out = 8'h00;
    endcase
  end

  assign busy_out = busy_r;

endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the paged program and coefficient window.
// Assumes the Avalon-MM timing and reset load described for dpcm_top.
`timescale 1ns/1ps
module tb_top;
  // ----------------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------------
  logic ref_clk_in = 1'b0; // Core clock, 25 ns period.
  logic rst_n_in = 1'b0; // Reset, active low.
  logic [6:0] avs_address_in = 7'h00; // Register index.
  logic avs_read_in = 1'b0; // Read request.
  logic avs_write_in = 1'b0; // Write request.
  logic [7:0] avs_writedata_in = 8'h00; // Write byte.
  logic [7:0] avs_readdata_out; // Read byte.
  logic avs_waitrequest_out; // Hold-off from the block.
  logic prog_mode_en_in = 1'b0; // Programmable engine mode.
  logic playback_pwr_in = 1'b0; // Playback channel power.
  logic [10:0] eng_addr_in = 11'h000; // Engine fetch number.
  logic [23:0] eng_instr_out; // Fetched word.
  int n_errors = 0; // Mismatches seen.
  int checks = 0; // Comparisons made.
  int seed = 46259; // Fixed seed, so a failing run repeats exactly.
  int dlist[10] = '{0, 1, 2, 3, 4, 5, 7, 59, 60, 255}; // Default probes.
  logic [23:0] rd; // Last byte read, widened for the compare task.
  logic [7:0] d; // Byte under test.
  logic [23:0] w; // Instruction word under test.
  int n, k, b, ln, i;

  always #12.5 ref_clk_in = ~ref_clk_in;

  dpcm_top dut
  (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .prog_mode_en_in(prog_mode_en_in),
    .playback_pwr_in(playback_pwr_in),
    .eng_addr_in(eng_addr_in),
    .eng_instr_out(eng_instr_out)
  );

  // ----------------------------------------------------------------------
  // Expectations and bus tasks
  // ----------------------------------------------------------------------
  // Reset value of a coefficient, kept apart from the design's own table.
  function automatic logic [23:0] def_coef(int c);
    case (c)
      1, 2: return 24'h011700;
      3: return 24'h7DD300;
      4, 7, 12, 17, 22, 27, 36, 39, 44, 49, 54, 59: return 24'h07FFFF;
      default: return 24'h000000;
    endcase
  endfunction

  // Non-negative random number below m.
  function automatic int rnd(int m);
    return ($random(seed) & 32'h7FFFFFFF) % m;
  endfunction

  task automatic finish_test();
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp,
                     input logic [23:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One transfer; the request stands until waitrequest is sampled low.
  // The bound covers the default load after reset with room to spare.
  task automatic acc(input bit wr, input logic [6:0] a,
                     input logic [7:0] wd);
    int t;
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= wd;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    for (t = 0; t < 600; t++)
    begin
      @(posedge ref_clk_in);
      if (avs_waitrequest_out === 1'b0)
        break;
    end
    rd = {16'h0000, avs_readdata_out};
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (t == 600)
    begin
      n_errors++;
      $display("wrong value waitrequest expected 0 seen 1");
      finish_test();
    end
  endtask

  // Selects the page that holds coefficient c of buffer bb.
  task automatic cpage(int bb, int c);
    acc(1'b1, 7'h00, 8'(bb ? 26 + c / 30 : 8 + c / 30));
  endtask

  // Reaches program byte l through its page and register.
  task automatic ibyte(bit wr, int l, logic [7:0] wd);
    acc(1'b1, 7'h00, 8'(8'h98 + l / 120));
    acc(wr, 7'(8 + l % 120), wd);
  endtask

  // Puts a fetch number on the engine port and returns after the answer.
  task automatic fetch(int f);
    eng_addr_in <= 11'(f);
    repeat (2) @(posedge ref_clk_in);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    // Selector and reserved registers; a request is raised during the load.
    acc(1'b0, 7'h00, 8'h00);
    chk("page", 24'h0, rd);
    for (k = 1; k < 8; k++)
    begin
      acc(1'b1, 7'(k), 8'h00);
      acc(1'b0, 7'(k), 8'h00);
      chk("reserved", 24'h0, rd);
    end
    for (k = 0; k < 4; k++)
    begin
      d = 8'(rnd(256));
      acc(1'b1, 7'h00, d);
      acc(1'b0, 7'h00, 8'h00);
      chk("page", {16'h0, d}, rd);
    end
    // Defaults of both buffers, every lane including the reserved one.
    foreach (dlist[j])
      for (b = 0; b < 2; b++)
      begin
        n = dlist[j];
        cpage(b, n);
        for (ln = 0; ln < 4; ln++)
        begin
          acc(1'b0, 7'(8 + 4 * (n % 30) + ln), 8'h00);
          w = (ln == 3) ? 24'h0 : def_coef(n) >> (16 - 8 * ln);
          chk("default", {16'h0, w[7:0]}, rd);
        end
      end
    // Random coefficient bytes, page edges and the last group first.
    for (i = 0; i < 24; i++)
    begin
      n = (i == 0) ? 29 : (i == 1) ? 30 : (i == 2) ? 255 : rnd(256);
      b = i % 2;
      ln = rnd(3);
      d = 8'(rnd(256));
      cpage(b, n);
      acc(1'b1, 7'(8 + 4 * (n % 30) + ln), d);
      acc(1'b1, 7'(8 + 4 * (n % 30) + 3), ~d);
      acc(1'b0, 7'(8 + 4 * (n % 30) + ln), 8'h00);
      chk("coef", {16'h0, d}, rd);
      acc(1'b0, 7'(8 + 4 * (n % 30) + 3), 8'h00);
      chk("coef reserved", 24'h0, rd);
    end
    // Past coefficient 255 the page holds nothing.
    acc(1'b1, 7'h00, 8'h10);
    acc(1'b1, 7'h48, 8'hA5);
    acc(1'b0, 7'h48, 8'h00);
    chk("unmapped", 24'h0, rd);
    // Program words, first and last included, with engine fetch.
    playback_pwr_in <= 1'b1;
    for (i = 0; i < 6; i++)
    begin
      k = (i == 0) ? 0 : (i == 1) ? 1399 : rnd(1400);
      w = 24'($random(seed));
      for (ln = 0; ln < 3; ln++)
        ibyte(1'b1, 3 * k + ln, 8'(w >> (16 - 8 * ln)));
      for (ln = 0; ln < 3; ln++)
      begin
        ibyte(1'b0, 3 * k + ln, 8'h00);
        chk("program byte", {16'h0, 8'(w >> (16 - 8 * ln))}, rd);
      end
      fetch(k);
      chk("fetch", w, eng_instr_out);
    end
    fetch(1400);
    chk("fetch beyond", 24'h0, eng_instr_out);
    // Locked while programmable and powered; either one off opens it.
    prog_mode_en_in <= 1'b1;
    ibyte(1'b0, 3 * k, 8'h00);
    chk("locked read", 24'h0, rd);
    ibyte(1'b1, 3 * k, ~w[23:16]);
    fetch(k);
    chk("locked fetch", w, eng_instr_out);
    playback_pwr_in <= 1'b0;
    ibyte(1'b0, 3 * k, 8'h00);
    chk("unpowered read", {16'h0, w[23:16]}, rd);
    prog_mode_en_in <= 1'b0;
    playback_pwr_in <= 1'b1;
    ibyte(1'b0, 3 * k, 8'h00);
    chk("unlocked read", {16'h0, w[23:16]}, rd);
    // A second reset restores the selector and the defaults.
    cpage(0, 3);
    acc(1'b1, 7'h14, 8'h55);
    rst_n_in <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    acc(1'b0, 7'h00, 8'h00);
    chk("page after reset", 24'h0, rd);
    cpage(0, 3);
    acc(1'b0, 7'h14, 8'h00);
    chk("default again", 24'h00007D, rd);
    finish_test();
  end
endmodule
